// File: design/dmt_direct_mode_transfer_ctrl.sv
// Purpose: executing-mode sequencer with direct transfer among run modes
// Assumes: sleepExec and wakeIrq are one-cycle pulses from same-clock logic
// Notes: intMaskBit mirrors the cpu interrupt mask bit, a same-clock level
`timescale 1ns/1ps
module dmt_direct_mode_transfer_ctrl
    import dmt_pkg::*;
#(
    parameter int SETTLE_BASE = SETTLE_BASE_STATES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [DATA_W-1:0] regRdData,
    input wire logic sleepExec,
    input wire logic intMaskBit,
    input wire logic wakeIrq,
    output logic [6:0] modeOut,
    output logic opClkEn,
    output logic dtExcStart,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    dmt_sys_one_type sysOne_ff;
    dmt_sys_two_type sysTwo_ff;
    logic [DATA_W-1:0] tmrMode_ff;
    logic [DATA_W-1:0] irqEn2_ff;
    logic [ST_W-1:0] status_ff;
    logic [ST_W-1:0] enable_ff;
    logic [DATA_W-1:0] rdData_ff;
    logic irq_ff;
    logic opClkEn_ff;
    logic dtExcStart_ff;

    dmt_state_type state_ff;
    dmt_state_type nxt_state;
    dmt_state_type target_ff;
    dmt_state_type nxt_target;
    logic direct_ff;
    logic nxt_direct;
    logic settle_ff;
    logic nxt_settle;

    logic wrSysOne;
    logic wrSysTwo;
    logic wrTmr;
    logic wrIrqEn2;
    logic wrClear;
    logic wrEnable;

    logic runMode;
    logic watchSel;
    logic dtAllowed;
    logic dtMatch;
    dmt_state_type dtTarget;
    logic dtSettle;
    logic dtViaWatch;
    dmt_state_type lpState;
    dmt_state_type wakeTarget;
    logic wakeOk;

    logic settleStart;
    logic settleDone;
    logic medTick;
    logic subTick;

    logic evDtDone;
    logic evLpEntry;
    logic evWakeDone;
    logic [ST_W-1:0] evVec;
    logic [ST_W-1:0] clrVec;

    ////////////////////////////////////////////////////////////////////////
    // register port decode

    // write strobes per register; the status and mode indices have none
    assign wrSysOne = regWrStb && (regAddr == ADR_SYS_ONE);
    assign wrSysTwo = regWrStb && (regAddr == ADR_SYS_TWO);
    assign wrTmr = regWrStb && (regAddr == ADR_TMR_MODE);
    assign wrIrqEn2 = regWrStb && (regAddr == ADR_IRQ_EN2);
    assign wrClear = regWrStb && (regAddr == ADR_CLEAR);
    assign wrEnable = regWrStb && (regAddr == ADR_ENABLE);

    // control registers written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sysOne_ff <= dmt_sys_one_type'(RST_SYS_ONE);
            sysTwo_ff <= dmt_sys_two_type'(RST_SYS_TWO);
            tmrMode_ff <= RST_TMR_MODE;
            irqEn2_ff <= RST_IRQ_EN2;
        end else if (ce) begin
            if (wrSysOne) begin
                sysOne_ff <= dmt_sys_one_type'(regWrData);
            end
            if (wrSysTwo) begin
                sysTwo_ff <= dmt_sys_two_type'(regWrData);
            end
            if (wrTmr) begin
                tmrMode_ff <= regWrData;
            end
            if (wrIrqEn2) begin
                irqEn2_ff <= regWrData;
            end
        end
    end

    // read data appear the cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= RST_ZERO;
        end else if (ce) begin
            rdData_ff <= RST_ZERO;
            if (regRdStb) begin
                unique case (regAddr)
                    ADR_SYS_ONE: rdData_ff <= sysOne_ff;
                    ADR_SYS_TWO: rdData_ff <= sysTwo_ff;
                    ADR_TMR_MODE: rdData_ff <= tmrMode_ff;
                    ADR_IRQ_EN2: rdData_ff <= irqEn2_ff;
                    ADR_STATUS: rdData_ff <= DATA_W'(status_ff);
                    ADR_CLEAR: rdData_ff <= RST_ZERO;
                    ADR_ENABLE: rdData_ff <= DATA_W'(enable_ff);
                    ADR_MODE: rdData_ff <= DATA_W'(state_ff);
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep decode against the present mode

    assign runMode = (state_ff == ST_ACT_HI) || (state_ff == ST_ACT_MED) ||
                     (state_ff == ST_SUBACT);
    assign watchSel = tmrMode_ff[TMR_WATCH_BIT];
    // masked cpu or disabled vector turns the attempt into low power
    assign dtAllowed = sysTwo_ff.directTransferEnable &&
                       irqEn2_ff[IRQ_EN2_DT_BIT] &&
                       !intMaskBit;

    // pattern match of bits sampled at the sleep against the mode
    always_comb begin
        dtMatch = 1'b0;
        dtTarget = ST_ACT_HI;
        dtSettle = 1'b0;
        dtViaWatch = 1'b0;
        unique case (state_ff)
            ST_ACT_HI: begin
                if (!sysOne_ff.standbySel && !sysOne_ff.lowSpeedOn &&
                    sysTwo_ff.mediumSpeedOn) begin
                    dtMatch = 1'b1;
                    dtTarget = ST_ACT_MED;
                end else if (sysOne_ff.standbySel &&
                             sysOne_ff.lowSpeedOn && watchSel) begin
                    dtMatch = 1'b1;
                    dtTarget = ST_SUBACT;
                    dtViaWatch = 1'b1;
                end
            end
            ST_ACT_MED: begin
                if (!sysOne_ff.standbySel && !sysOne_ff.lowSpeedOn &&
                    !sysTwo_ff.mediumSpeedOn) begin
                    dtMatch = 1'b1;
                    dtTarget = ST_ACT_HI;
                end else if (sysOne_ff.standbySel &&
                             sysOne_ff.lowSpeedOn && watchSel) begin
                    dtMatch = 1'b1;
                    dtTarget = ST_SUBACT;
                    dtViaWatch = 1'b1;
                end
            end
            ST_SUBACT: begin
                if (sysOne_ff.standbySel && !sysOne_ff.lowSpeedOn &&
                    watchSel) begin
                    dtMatch = 1'b1;
                    dtViaWatch = 1'b1;
                    dtSettle = 1'b1;
                    dtTarget = sysTwo_ff.mediumSpeedOn ? ST_ACT_MED :
                               ST_ACT_HI;
                end
            end
            default: begin
                dtMatch = 1'b0;
            end
        endcase
    end

    // ordinary low-power choice; standby with watch selected parks in the watch hold, else the sleep hold
    assign lpState = (sysOne_ff.standbySel && watchSel) ? ST_WATCH_LP :
                     ST_SLEEP_LP;

    // wake destination follows the speed bits at the interrupt
    always_comb begin
        if (sysOne_ff.lowSpeedOn) begin
            wakeTarget = ST_SUBACT;
        end else if (sysTwo_ff.mediumSpeedOn) begin
            wakeTarget = ST_ACT_MED;
        end else begin
            wakeTarget = ST_ACT_HI;
        end
    end

    // a masked cpu can never leave the hold states by interrupt
    assign wakeOk = wakeIrq && !intMaskBit;

    ////////////////////////////////////////////////////////////////////////
    // mode sequencer

    always_comb begin
        nxt_state = state_ff;
        nxt_target = target_ff;
        nxt_direct = direct_ff;
        nxt_settle = settle_ff;
        settleStart = 1'b0;
        evDtDone = 1'b0;
        evLpEntry = 1'b0;
        evWakeDone = 1'b0;
        unique case (state_ff)
            ST_ACT_HI, ST_ACT_MED, ST_SUBACT: begin
                if (sleepExec && dtAllowed && dtMatch) begin
                    nxt_target = dtTarget;
                    nxt_direct = 1'b1;
                    nxt_settle = dtSettle;
                    settleStart = dtSettle;
                    nxt_state = dtViaWatch ? ST_VIA_WATCH : ST_VIA_SLEEP;
                end else if (sleepExec) begin
                    nxt_state = lpState;
                    nxt_direct = 1'b0;
                    evLpEntry = 1'b1;
                end
            end
            ST_VIA_SLEEP: begin
                nxt_state = target_ff;
                evDtDone = direct_ff;
                evWakeDone = !direct_ff;
            end
            ST_VIA_WATCH: begin
                if (!settle_ff || settleDone) begin
                    nxt_state = target_ff;
                    nxt_settle = 1'b0;
                    evDtDone = direct_ff;
                    evWakeDone = !direct_ff;
                end
            end
            ST_SLEEP_LP: begin
                if (wakeOk) begin
                    nxt_target = wakeTarget;
                    nxt_state = ST_VIA_SLEEP;
                end
            end
            ST_WATCH_LP: begin
                if (wakeOk) begin
                    nxt_target = wakeTarget;
                    nxt_settle = (wakeTarget != ST_SUBACT);
                    settleStart = (wakeTarget != ST_SUBACT);
                    nxt_state = ST_VIA_WATCH;
                end
            end
            default: begin
                nxt_state = ST_ACT_HI;
            end
        endcase
    end

    // current mode and the pending destination
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_ACT_HI;
            target_ff <= ST_ACT_HI;
            direct_ff <= 1'b0;
            settle_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            target_ff <= nxt_target;
            direct_ff <= nxt_direct;
            settle_ff <= nxt_settle;
        end
    end

    // exception start is a one-cycle pulse as the new mode begins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dtExcStart_ff <= 1'b0;
        end else if (ce) begin
            dtExcStart_ff <= evDtDone;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clocks of the executing modes

    dmt_settle_timer #(
        .BASE_STATES(SETTLE_BASE)
    ) u_settle (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .start(settleStart),
        .sel(sysOne_ff.settleWaitSel),
        .done(settleDone)
    );

    dmt_rate_div #(
        .MIN_LOG2(MED_DIV_MIN_LOG2)
    ) u_med_div (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .sel(sysOne_ff.mediumDivSel),
        .tick(medTick)
    );

    dmt_rate_div #(
        .MIN_LOG2(SUB_DIV_MIN_LOG2)
    ) u_sub_div (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .sel(sysTwo_ff.subDivSel),
        .tick(subTick)
    );

    // operation enable: full rate, divided rate, or halted in transit and in the hold states
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opClkEn_ff <= 1'b0;
        end else if (ce) begin
            unique case (nxt_state)
                ST_ACT_HI: opClkEn_ff <= 1'b1;
                ST_ACT_MED: opClkEn_ff <= medTick;
                ST_SUBACT: opClkEn_ff <= subTick;
                default: opClkEn_ff <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, clear and enable

    assign evVec = {evWakeDone, evLpEntry, evDtDone};
    assign clrVec = wrClear ? regWrData[ST_W-1:0] : '0;

    // sticky bits; a new event beats a clear in the same cycle
    generate
        for (genvar i = 0; i < ST_W; i++) begin : g_status
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    status_ff[i] <= 1'b0;
                end else if (ce) begin
                    if (evVec[i]) begin
                        status_ff[i] <= 1'b1;
                    end else if (clrVec[i]) begin
                        status_ff[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // enable mask and level interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff <= '0;
            irq_ff <= 1'b0;
        end else if (ce) begin
            if (wrEnable) begin
                enable_ff <= regWrData[ST_W-1:0];
            end
            irq_ff <= |(status_ff & enable_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops

    assign regRdData = rdData_ff;
    assign modeOut = state_ff;
    assign opClkEn = opClkEn_ff;
    assign dtExcStart = dtExcStart_ff;
    assign irq = irq_ff;

endmodule : dmt_direct_mode_transfer_ctrl

// File: design/dmt_pkg.sv
// Purpose: shared constants and types of the direct mode transfer controller
// Assumes: one 100 MHz clock, 8-bit register port with 3-bit word index
// Notes: one "state" of a settling wait is one clock cycle here
// Contract
// - medium-speed mode runs at the rate picked by the medium divider bits.
// - high-speed, medium-speed and subactive modes all keep executing code.
// - sleep with direct-transfer enable set starts a direct transfer.
// - a finished direct transfer starts direct-transfer exception handling.
// - direct-transfer interrupt disabled means plain sleep or watch entry.
// - interrupt mask set on attempt gives sleep or watch no interrupt clears.
// - high-speed to medium-speed through sleep on the given bit pattern.
// - medium-speed to high-speed through sleep on the given bit pattern.
// - high-speed to subactive through watch on the given bit pattern.
// - medium-speed to subactive through watch on the given bit pattern.
// - subactive to high-speed through watch after the settling wait.
// - subactive to medium-speed through watch after the settling wait.
package dmt_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;

    // register word indices
    localparam logic [ADDR_W-1:0] ADR_SYS_ONE = 3'h0;
    localparam logic [ADDR_W-1:0] ADR_SYS_TWO = 3'h1;
    localparam logic [ADDR_W-1:0] ADR_TMR_MODE = 3'h2;
    localparam logic [ADDR_W-1:0] ADR_IRQ_EN2 = 3'h3;
    localparam logic [ADDR_W-1:0] ADR_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] ADR_CLEAR = 3'h5;
    localparam logic [ADDR_W-1:0] ADR_ENABLE = 3'h6;
    localparam logic [ADDR_W-1:0] ADR_MODE = 3'h7;

    // reset values
    localparam logic [DATA_W-1:0] RST_SYS_ONE = 8'h00;
    localparam logic [DATA_W-1:0] RST_SYS_TWO = 8'h00;
    localparam logic [DATA_W-1:0] RST_TMR_MODE = 8'h00;
    localparam logic [DATA_W-1:0] RST_IRQ_EN2 = 8'h00;
    localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;

    // field positions
    localparam int TMR_WATCH_BIT = 3;
    localparam int IRQ_EN2_DT_BIT = 0;
    localparam int ST_DT_DONE = 0;
    localparam int ST_LP_ENTRY = 1;
    localparam int ST_WAKE_DONE = 2;
    localparam int ST_W = 3;

    // timing
    localparam int SETTLE_BASE_STATES = 8192;
    localparam int SETTLE_CNT_W = 18;
    localparam int MED_DIV_MIN_LOG2 = 4;
    localparam int SUB_DIV_MIN_LOG2 = 1;
    localparam int DIV_CNT_W = 8;

    typedef struct packed {
        logic standbySel;
        logic [2:0] settleWaitSel;
        logic lowSpeedOn;
        logic rsvd;
        logic [1:0] mediumDivSel;
    } dmt_sys_one_type;

    typedef struct packed {
        logic [3:0] rsvd;
        logic directTransferEnable;
        logic mediumSpeedOn;
        logic [1:0] subDivSel;
    } dmt_sys_two_type;

    typedef enum logic [6:0] {
        ST_ACT_HI = 7'h01,
        ST_ACT_MED = 7'h02,
        ST_SUBACT = 7'h04,
        ST_VIA_SLEEP = 7'h08,
        ST_VIA_WATCH = 7'h10,
        ST_SLEEP_LP = 7'h20,
        ST_WATCH_LP = 7'h40
    } dmt_state_type;

endpackage : dmt_pkg

// File: design/dmt_settle_timer.sv
// Purpose: oscillator settling wait counter
// Assumes: start is a one-cycle pulse on the same clock
// Notes: done pulses once the selected number of states has elapsed
`timescale 1ns/1ps
module dmt_settle_timer
    import dmt_pkg::*;
#(
    parameter int BASE_STATES = SETTLE_BASE_STATES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    input wire logic [2:0] sel,
    output logic done
);

    logic [SETTLE_CNT_W-1:0] cnt_ff;
    logic run_ff;
    logic done_ff;
    logic [SETTLE_CNT_W-1:0] limitVal;

    // top select bit picks the longest wait, the rest double each step
    always_comb begin
        if (sel[2]) begin
            limitVal = SETTLE_CNT_W'(BASE_STATES) << 4;
        end else begin
            limitVal = SETTLE_CNT_W'(BASE_STATES) << sel[1:0];
        end
    end

    // countdown; a new start restarts the wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= 1'b0;
            if (start) begin
                cnt_ff <= limitVal - SETTLE_CNT_W'(1);
                run_ff <= 1'b1;
            end else if (run_ff) begin
                if (cnt_ff == '0) begin
                    run_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - SETTLE_CNT_W'(1);
                end
            end
        end
    end

    assign done = done_ff;

endmodule : dmt_settle_timer

// File: design/dmt_rate_div.sv
// Purpose: power-of-two rate divider giving a one-cycle tick
// Assumes: sel changes only between program phases
// Notes: period is 2 to the power of MIN_LOG2 plus sel cycles
`timescale 1ns/1ps
module dmt_rate_div
    import dmt_pkg::*;
#(
    parameter int MIN_LOG2 = MED_DIV_MIN_LOG2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [1:0] sel,
    output logic tick
);

    logic [DIV_CNT_W-1:0] cnt_ff;
    logic tick_ff;
    logic [DIV_CNT_W-1:0] lastVal;

    assign lastVal = (DIV_CNT_W'(1) << (MIN_LOG2 + int'(sel))) -
                     DIV_CNT_W'(1);

    // free-running count, tick registered in the cycle after the last count of each period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (ce) begin
            if (cnt_ff >= lastVal) begin
                cnt_ff <= '0;
                tick_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + DIV_CNT_W'(1);
                tick_ff <= 1'b0;
            end
        end
    end

    assign tick = tick_ff;

endmodule : dmt_rate_div

// File: test/dmt_ctrl_asserts.sv
// Purpose: port checks of the mode sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes: sees only the ports of the top module
`timescale 1ns/1ps
module dmt_ctrl_asserts
    import dmt_pkg::*;
#(
    parameter int SETTLE_BASE = SETTLE_BASE_STATES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic regRdStb,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic sleepExec,
    input wire logic intMaskBit,
    input wire logic [6:0] modeOut,
    input wire logic opClkEn,
    input wire logic dtExcStart
);
    localparam int MAX_SETTLE = (SETTLE_BASE << 4) + 1;
    logic [17:0] waitCnt_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // cycles spent in watch transit, so settle length can be bounded
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt_ff <= '0;
        end else if (ce) begin
            waitCnt_ff <= (modeOut == 7'h10) ? waitCnt_ff + 18'h1 : '0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_sleepTaken;
        ce && sleepExec && modeOut inside {7'h01, 7'h02, 7'h04};
    endsequence
    sequence s_wakeSleep;
        modeOut == 7'h20 ##1 modeOut == 7'h08;
    endsequence
    a_sleep_leaves_run: assert property (
        s_sleepTaken |=> modeOut inside {7'h08, 7'h10, 7'h20, 7'h40})
        else $error("sleep did not leave run mode");
    a_run_mode_holds: assert property (
        ce && !sleepExec && modeOut inside {7'h01, 7'h02, 7'h04}
        |=> $stable(modeOut))
        else $error("run mode changed without sleep");
    a_exc_on_arrival: assert property (
        dtExcStart |-> modeOut inside {7'h01, 7'h02, 7'h04}
        && $past(modeOut) inside {7'h08, 7'h10})
        else $error("exception start outside arrival");
    a_sleep_one_cycle: assert property (
        ce && modeOut == 7'h08 |=> modeOut != 7'h08)
        else $error("sleep transit longer than one cycle");
    a_masked_hold: assert property (
        ce && intMaskBit && modeOut inside {7'h20, 7'h40}
        |=> $stable(modeOut))
        else $error("masked hold was left");
    a_wake_no_exc: assert property (
        s_wakeSleep |=> !dtExcStart)
        else $error("exception start after plain wake");
    a_hi_clock_runs: assert property (
        $past(rst_n) && $past(ce) && $past(modeOut) == 7'h01
        && modeOut == 7'h01 |-> opClkEn)
        else $error("no operation clock in high-speed mode");
    a_med_tick_gap: assert property (
        modeOut == 7'h02 && opClkEn
        |=> (modeOut != 7'h02 || !opClkEn) [*8])
        else $error("medium tick too frequent");
    a_settle_bound: assert property (
        modeOut == 7'h10 |-> waitCnt_ff <= MAX_SETTLE)
        else $error("watch transit overstayed");
    a_settle_floor: assert property (
        $fell(modeOut == 7'h10) && modeOut inside {7'h01, 7'h02}
        |-> waitCnt_ff >= SETTLE_BASE + 1)
        else $error("active mode before settling wait");
    a_mode_read: assert property (
        ce && regRdStb && regAddr == ADR_MODE
        |=> regRdData == {1'b0, $past(modeOut)})
        else $error("mode word read wrong");
endmodule : dmt_ctrl_asserts

bind dmt_direct_mode_transfer_ctrl dmt_ctrl_asserts #(
    .SETTLE_BASE(SETTLE_BASE)
) i_dmt_ctrl_asserts (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .regAddr(regAddr),
    .regRdStb(regRdStb),
    .regRdData(regRdData),
    .sleepExec(sleepExec),
    .intMaskBit(intMaskBit),
    .modeOut(modeOut),
    .opClkEn(opClkEn),
    .dtExcStart(dtExcStart)
);

// File: test/testbench.sv
// Purpose: self-checking bench of the mode sequencer
// Assumes: settling base shortened to 4 clocks
// Notes: random divider and settle selects, fixed seed
`timescale 1ns/1ps
module testbench
    import dmt_pkg::*;
;
    localparam int BASE = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic sleepExec = 1'b0;
    logic intMaskBit = 1'b0;
    logic wakeIrq = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic [6:0] modeOut;
    logic opClkEn;
    logic dtExcStart;
    logic irq;
    logic [7:0] v;
    logic [7:0] d;
    logic [2:0] s;
    int n_fail = 0;
    int comparisons = 0;
    int k;
    int n;
    ////////////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;

    dmt_direct_mode_transfer_ctrl #(
        .SETTLE_BASE(BASE)
    ) i_dmt_direct_mode_transfer_ctrl (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrStb(regWrStb),
        .regRdStb(regRdStb),
        .regRdData(regRdData),
        .sleepExec(sleepExec),
        .intMaskBit(intMaskBit),
        .wakeIrq(wakeIrq),
        .modeOut(modeOut),
        .opClkEn(opClkEn),
        .dtExcStart(dtExcStart),
        .irq(irq)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [7:0] e,
            input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [2:0] a, input logic [7:0] w);
        @(posedge clk);
        regAddr <= a;
        regWrData <= w;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
    endtask : wr

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] r);
        @(posedge clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1;
        r = regRdData;
    endtask : rd

    // pulse sleep or wake, then follow the transit until it ends
    task automatic go(input bit wake, input logic [6:0] via,
            input logic [6:0] dest, input int waitN, input logic exc);
        int c;
        @(posedge clk);
        if (wake) wakeIrq <= 1'b1;
        else sleepExec <= 1'b1;
        @(posedge clk);
        wakeIrq <= 1'b0;
        sleepExec <= 1'b0;
        #1;
        chk("transit", {1'b0, via}, {1'b0, modeOut});
        c = 0;
        while (modeOut === via && via != dest && c < 300) begin
            cyc(1);
            c++;
        end
        chk("dwell", 8'(waitN), 8'(c));
        chk("mode", {1'b0, dest}, {1'b0, modeOut});
        chk("exc", {7'h00, exc}, {7'h00, dtExcStart});
    endtask : go

    function automatic int settle(input logic [2:0] sel);
        return (BASE << (sel[2] ? 4 : sel[1:0])) + 1;
    endfunction : settle
    ////////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial begin
        k = $urandom(38);
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (k = 0; k < 8; k++) begin
            rd(3'(k), v);
            chk("reset", (k == 7) ? 8'h01 : 8'h00, v);
        end
        for (k = 0; k < 4; k++) begin
            d = 8'($urandom);
            wr(3'(k), d);
            rd(3'(k), v);
            chk("rw", d, v);
        end
        for (k = 4; k < 6; k++) begin
            wr(3'(k), 8'hFF);
            rd(3'(k), v);
            chk("ro", 8'h00, v);
        end
        // direct loop through all six moves
        d = 8'($urandom % 2);
        wr(ADR_IRQ_EN2, 8'h01);
        wr(ADR_ENABLE, 8'h01);
        wr(ADR_TMR_MODE, 8'h08);
        wr(ADR_SYS_ONE, d);
        wr(ADR_SYS_TWO, 8'h0C);
        go(0, 7'h08, 7'h02, 1, 1'b1);
        n = 0;
        repeat (64) begin
            cyc(1);
            if (opClkEn === 1'b1) n++;
        end
        chk("ticks", 8'(64 >> (4 + d)), 8'(n));
        rd(ADR_STATUS, v);
        chk("status", 8'h01, v);
        chk("irq", 8'h01, {7'h00, irq});
        wr(ADR_CLEAR, 8'h01);
        cyc(2);
        chk("irq", 8'h00, {7'h00, irq});
        wr(ADR_SYS_TWO, 8'h08);
        go(0, 7'h08, 7'h01, 1, 1'b1);
        wr(ADR_SYS_ONE, 8'h88);
        ce <= 1'b0;
        go(0, 7'h01, 7'h01, 0, 1'b0);
        ce <= 1'b1;
        go(0, 7'h10, 7'h04, 1, 1'b1);
        s = 3'($urandom);
        wr(ADR_SYS_ONE, {1'b1, s, 4'h0});
        wr(ADR_SYS_TWO, 8'h0C);
        go(0, 7'h10, 7'h02, settle(s), 1'b1);
        wr(ADR_SYS_ONE, 8'h88);
        go(0, 7'h10, 7'h04, 1, 1'b1);
        s = 3'b100;
        wr(ADR_SYS_ONE, {1'b1, s, 4'h0});
        wr(ADR_SYS_TWO, 8'h08);
        go(0, 7'h10, 7'h01, settle(s), 1'b1);
        // fallbacks: interrupt disabled, then cpu mask set
        wr(ADR_ENABLE, 8'h00);
        wr(ADR_CLEAR, 8'h07);
        wr(ADR_SYS_ONE, 8'h00);
        wr(ADR_SYS_TWO, 8'h0C);
        wr(ADR_IRQ_EN2, 8'h00);
        go(0, 7'h20, 7'h20, 0, 1'b0);
        go(1, 7'h08, 7'h02, 1, 1'b0);
        wr(ADR_SYS_ONE, 8'h80);
        go(0, 7'h40, 7'h40, 0, 1'b0);
        go(1, 7'h10, 7'h02, settle(3'b000), 1'b0);
        chk("irq", 8'h00, {7'h00, irq});
        wr(ADR_ENABLE, 8'h02);
        cyc(2);
        chk("irq", 8'h01, {7'h00, irq});
        wr(ADR_IRQ_EN2, 8'h01);
        wr(ADR_SYS_TWO, 8'h08);
        wr(ADR_SYS_ONE, 8'h00);
        intMaskBit <= 1'b1;
        go(0, 7'h20, 7'h20, 0, 1'b0);
        go(1, 7'h20, 7'h20, 0, 1'b0);
        intMaskBit <= 1'b0;
        go(1, 7'h08, 7'h01, 1, 1'b0);
        conclude();
    end
endmodule : testbench
